//--- pkg/ecs_pkg.sv
// constants, stop modes and states of the link error supervisor
//------------------------------------------------------------
// Notes on behaviour
// - receive errors past retry limit trip link
// - limit 9999: never trip, raise minor alarm
// - minor alarm routed to terminal codes 98/198
// - retry supervision only with vendor protocol
// - check interval 9999 disables loss detection
// - interval zero trips on entering network mode
// - silence longer than interval trips the link
// - any frame clears the silence counter
// - supervision starts at first frame in mode
// - ordinary decel and accel ramps are used
// - restart resumes commands held before fault
// - restart mode: error cleared during decel, accelerate again
// - fault history written only with fault output
//------------------------------------------------------------
package ecs_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned TICK_NS       = 100000000;   // 0.1 s setting step
   localparam int unsigned TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int          SET_W         = 14;
   localparam logic [13:0] SET_OFF       = 14'h270F;    // 9999
   localparam logic [13:0] SET_ZERO      = 14'h0000;
   localparam logic [13:0] CHECK_MAX     = 14'h270E;    // 999.8 s
   localparam logic [13:0] RETRY_MAX     = 14'h000A;    // 10
   localparam int          CNT_W         = 4;

   localparam int          FUNC_W        = 8;
   localparam logic [7:0]  FUNC_LF_POS   = 8'h62;       // 98
   localparam logic [7:0]  FUNC_LF_NEG   = 8'hC6;       // 198
   localparam int          TERM_N        = 3;

   localparam logic [1:0]  STOP_COAST    = 2'h0;
   localparam logic [1:0]  STOP_DECEL    = 2'h1;
   localparam logic [1:0]  STOP_RESTART  = 2'h2;

   localparam logic        PROTO_VENDOR  = 1'b0;
   localparam int          SPEED_W       = 16;

   typedef enum logic [1:0] {ST_RUN, ST_DECEL, ST_HOLD, ST_WAIT} ecs_state_e;
endpackage

//--- pkg/ecs_loss_if.sv
// carrier between the supervisor and its silence timer
`timescale 1ns/1ps
interface ecs_loss_if;
   logic                     enable;
   logic [ecs_pkg::SET_W-1:0] interval;
   logic                     frame_seen;
   logic                     expired;
   modport timer (input enable, input interval, input frame_seen, output expired);
   modport ctrl  (output enable, output interval, output frame_seen, input expired);
endinterface

//--- core/ecs_loss_timer.sv
// silence timer: counts 0.1 s ticks since the last frame
`timescale 1ns/1ps
module ecs_loss_timer #(
   parameter int unsigned TICK_CYCLES = ecs_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic         ref_clk,
   input wire logic         rst_n,
   // supervisor side
   ecs_loss_if.timer        lk
);
   localparam int PW = $clog2(TICK_CYCLES + 1);

   logic [PW-1:0]               pre_q, pre_d;
   logic [ecs_pkg::SET_W-1:0]   ela_q, ela_d;
   logic                        exp_q, exp_d;
   logic                        tick;

   assign tick       = (pre_q == PW'(TICK_CYCLES - 1));
   assign lk.expired = exp_q;

   always_comb begin
      pre_d = tick ? '0 : pre_q + PW'(1);
      ela_d = ela_q;
      exp_d = exp_q;
      if (!lk.enable || lk.frame_seen) begin
         pre_d = '0;
         ela_d = '0;
         exp_d = 1'b0;
      end else if (tick) begin
         // strictly longer than the interval: trip on the tick after it is reached
         if (ela_q >= lk.interval) exp_d = 1'b1;
         else ela_d = ela_q + ecs_pkg::SET_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= '0;
         ela_q <= '0;
         exp_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         ela_q <= ela_d;
         exp_q <= exp_d;
      end
   end

   a_frame_clears_loss: assert property (@(posedge ref_clk) disable iff (!rst_n)
      lk.frame_seen |=> !exp_q && ela_q == '0)
      else $error("frame did not clear silence timer");
endmodule // ecs_loss_timer

//--- core/ecs_supervisor.sv
// link error supervisor: retry count, signal loss and stop behaviour
`timescale 1ns/1ps
module ecs_supervisor #(
   parameter int unsigned TICK_CYCLES = ecs_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   // receiver events, same clock
   input  wire logic                          frame_ok,
   input  wire logic                          frame_err,
   // settings
   input  wire logic                          protocol_sel,
   input  wire logic [ecs_pkg::SET_W-1:0]     retry_limit_setting,
   input  wire logic [ecs_pkg::SET_W-1:0]     check_interval_setting,
   input  wire logic [1:0]                    fault_stop_mode,
   input  wire logic [ecs_pkg::FUNC_W-1:0]    output_terminal_function_a,
   input  wire logic [ecs_pkg::FUNC_W-1:0]    output_terminal_function_b,
   input  wire logic [ecs_pkg::FUNC_W-1:0]    output_terminal_function_c,
   // drive state
   input  wire logic                          network_command_mode,
   input  wire logic                          motor_stopped,
   input  wire logic                          fault_reset_pin,
   input  wire logic                          run_cmd_in,
   input  wire logic [ecs_pkg::SPEED_W-1:0]   speed_cmd_in,
   // drive control
   output logic                               coast_cmd,
   output logic                               decel_cmd,
   output logic                               accel_restart,
   output logic                               run_cmd_out,
   output logic [ecs_pkg::SPEED_W-1:0]        speed_cmd_out,
   // indication and outputs
   output logic                               link_fault_trip,
   output logic                               fault_output,
   output logic                               fault_history_wr,
   output logic                               minor_fault_alarm,
   output logic [ecs_pkg::TERM_N-1:0]         term_out
);
   //------------------------------------------------------------
   // input capture
   //------------------------------------------------------------
   logic res_m_q, res_s_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_m_q <= 1'b0;
         res_s_q <= 1'b0;
      end else begin
         res_m_q <= fault_reset_pin;
         res_s_q <= res_m_q;
      end
   end

   //------------------------------------------------------------
   // setting decode
   //------------------------------------------------------------
   logic                      vendor, lf_only, chk_on, chk_zero, zero_trip, any_frame;
   logic [ecs_pkg::CNT_W-1:0] limit_eff;
   assign vendor    = (protocol_sel == ecs_pkg::PROTO_VENDOR);
   assign lf_only   = (retry_limit_setting == ecs_pkg::SET_OFF);
   // out-of-range limits are clamped rather than treated as a new mode
   assign limit_eff = (retry_limit_setting > ecs_pkg::RETRY_MAX) ?
                      ecs_pkg::CNT_W'(ecs_pkg::RETRY_MAX) :
                      retry_limit_setting[ecs_pkg::CNT_W-1:0];
   assign chk_on    = (check_interval_setting != ecs_pkg::SET_OFF) &&
                      (check_interval_setting != ecs_pkg::SET_ZERO) &&
                      (check_interval_setting <= ecs_pkg::CHECK_MAX);
   assign chk_zero  = (check_interval_setting == ecs_pkg::SET_ZERO);
   assign zero_trip = chk_zero && network_command_mode;
   assign any_frame = frame_ok || frame_err;

   //------------------------------------------------------------
   // retry counter, minor alarm, loss arming
   //------------------------------------------------------------
   ecs_pkg::ecs_state_e        st_q, st_d;
   logic [ecs_pkg::CNT_W-1:0]  cnt_q, cnt_d;
   logic                       lf_q, lf_d, arm_q, arm_d, retry_trip;

   assign retry_trip = vendor && !lf_only && frame_err &&
                       (cnt_q + ecs_pkg::CNT_W'(1) > limit_eff);

   always_comb begin
      cnt_d = cnt_q;
      lf_d  = lf_q;
      arm_d = arm_q;
      if (frame_ok) begin
         cnt_d = '0;
         lf_d  = 1'b0;
      end
      if (vendor && frame_err) begin
         if (lf_only) lf_d = 1'b1;
         else if (retry_trip) cnt_d = '0;
         else cnt_d = cnt_q + ecs_pkg::CNT_W'(1);
      end
      if (!network_command_mode) arm_d = 1'b0;
      else if (any_frame) arm_d = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         lf_q  <= 1'b0;
         arm_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lf_q  <= lf_d;
         arm_q <= arm_d;
      end
   end

   assign minor_fault_alarm = lf_q;

   genvar gi;
   generate
      for (gi = 0; gi < ecs_pkg::TERM_N; gi++) begin : g_term
         logic [ecs_pkg::FUNC_W-1:0] fcode;
         if (gi == 0) begin : g_a
            assign fcode = output_terminal_function_a;
         end else if (gi == 1) begin : g_b
            assign fcode = output_terminal_function_b;
         end else begin : g_c
            assign fcode = output_terminal_function_c;
         end
         assign term_out[gi] = (fcode == ecs_pkg::FUNC_LF_POS) ? lf_q :
                               (fcode == ecs_pkg::FUNC_LF_NEG) ? !lf_q : 1'b0;
      end
   endgenerate

   //------------------------------------------------------------
   // silence timer
   //------------------------------------------------------------
   ecs_loss_if lk ();
   assign lk.enable     = arm_q && network_command_mode && chk_on;
   assign lk.interval   = check_interval_setting;
   assign lk.frame_seen = any_frame;

   ecs_loss_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .lk      (lk.timer)
   );

   //------------------------------------------------------------
   // stop and restart sequencing
   //------------------------------------------------------------
   logic                       trip_evt, err_gone, hist_q, hist_d, acc_q, acc_d, run_q, run_d;
   logic [ecs_pkg::SPEED_W-1:0] spd_q, spd_d;

   assign trip_evt = retry_trip || lk.expired || zero_trip;
   // the error counts as removed once the master talks cleanly again
   assign err_gone = frame_ok && !zero_trip;

   always_comb begin
      st_d   = st_q;
      hist_d = 1'b0;
      acc_d  = 1'b0;
      run_d  = run_q;
      spd_d  = spd_q;
      case (st_q)
         ecs_pkg::ST_RUN: begin
            run_d = run_cmd_in;
            spd_d = speed_cmd_in;
            if (trip_evt) begin
               if (fault_stop_mode == ecs_pkg::STOP_COAST) begin
                  st_d   = ecs_pkg::ST_HOLD;
                  hist_d = 1'b1;
               end else begin
                  st_d   = ecs_pkg::ST_DECEL;
               end
            end
         end
         ecs_pkg::ST_DECEL: begin
            if (fault_stop_mode == ecs_pkg::STOP_RESTART && err_gone) begin
               st_d  = ecs_pkg::ST_RUN;
               acc_d = 1'b1;
            end else if (motor_stopped) begin
               if (fault_stop_mode == ecs_pkg::STOP_RESTART) begin
                  st_d = ecs_pkg::ST_WAIT;
               end else begin
                  st_d   = ecs_pkg::ST_HOLD;
                  hist_d = 1'b1;
               end
            end
         end
         ecs_pkg::ST_HOLD: begin
            if (res_s_q) st_d = ecs_pkg::ST_RUN;
         end
         ecs_pkg::ST_WAIT: begin
            if (err_gone) begin
               st_d  = ecs_pkg::ST_RUN;
               acc_d = 1'b1;
            end
         end
         default: st_d = ecs_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q   <= ecs_pkg::ST_RUN;
         hist_q <= 1'b0;
         acc_q  <= 1'b0;
         run_q  <= 1'b0;
         spd_q  <= '0;
      end else begin
         st_q   <= st_d;
         hist_q <= hist_d;
         acc_q  <= acc_d;
         run_q  <= run_d;
         spd_q  <= spd_d;
      end
   end

   // snapshot stays frozen through the fault so a restart resumes it
   assign run_cmd_out      = run_q;
   assign speed_cmd_out    = spd_q;
   assign coast_cmd        = (st_q == ecs_pkg::ST_HOLD);
   assign decel_cmd        = (st_q == ecs_pkg::ST_DECEL);
   assign accel_restart    = acc_q;
   assign link_fault_trip  = (st_q == ecs_pkg::ST_HOLD) || (st_q == ecs_pkg::ST_WAIT);
   assign fault_output     = (st_q == ecs_pkg::ST_HOLD);
   assign fault_history_wr = hist_q;

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_decel_mode2_clear;
      st_q == ecs_pkg::ST_DECEL && fault_stop_mode == ecs_pkg::STOP_RESTART && err_gone;
   endsequence
   sequence s_coast_trip;
      st_q == ecs_pkg::ST_RUN && trip_evt && fault_stop_mode == ecs_pkg::STOP_COAST;
   endsequence

   a_retry_limit_trip: assert property (st_q == ecs_pkg::ST_RUN && retry_trip
      |=> st_q != ecs_pkg::ST_RUN && cnt_q == '0)
      else $error("retry limit did not trip");
   a_lf_on_error: assert property (vendor && lf_only && frame_err
      |=> minor_fault_alarm && !$past(retry_trip))
      else $error("minor alarm missing on receive error");
   a_term_polarity: assert property (output_terminal_function_a == ecs_pkg::FUNC_LF_NEG
      |-> term_out[0] == !minor_fault_alarm)
      else $error("terminal polarity wrong");
   a_modbus_ignores: assert property (!vendor && frame_err && !frame_ok
      |=> cnt_q == $past(cnt_q) && lf_q == $past(lf_q))
      else $error("retry logic active under modbus");
   a_check_off: assert property (check_interval_setting == ecs_pkg::SET_OFF
      |-> !lk.enable)
      else $error("loss timer enabled with check off");
   a_zero_interval: assert property (st_q == ecs_pkg::ST_RUN && zero_trip
      |=> st_q != ecs_pkg::ST_RUN)
      else $error("zero interval did not trip");
   a_good_frame_clears: assert property (frame_ok && !frame_err
      |=> cnt_q == '0)
      else $error("good frame did not clear count");
   a_coast_fault_now: assert property (s_coast_trip
      |=> coast_cmd && fault_output && fault_history_wr ##1 !fault_history_wr)
      else $error("coast stop without fault output");
   a_decel_reaccel: assert property (s_decel_mode2_clear
      |=> st_q == ecs_pkg::ST_RUN && accel_restart && !link_fault_trip)
      else $error("no reacceleration after error cleared");
   a_hist_needs_output: assert property (fault_history_wr
      |-> fault_output && fault_stop_mode != ecs_pkg::STOP_RESTART)
      else $error("history write without fault output");
   a_restart_resumes: assert property (st_q == ecs_pkg::ST_WAIT && err_gone
      |=> st_q == ecs_pkg::ST_RUN && run_cmd_out == $past(run_q))
      else $error("restart lost held command");
endmodule // ecs_supervisor

//--- dv/ecs_host_model.sv
// host link master model: emits frame events towards the supervisor
`timescale 1ns/1ps
module ecs_host_model (
   // clock
   input  wire logic ref_clk,
   // frame events
   output logic      frame_ok,
   output logic      frame_err
);
   initial begin
      frame_ok  = 1'b0;
      frame_err = 1'b0;
   end

   // one frame: a one-cycle pulse launched just after an edge
   task automatic send(input logic err);
      @(posedge ref_clk);
      #2;
      frame_ok  = ~err;
      frame_err = err;
      @(posedge ref_clk);
      #2;
      frame_ok  = 1'b0;
      frame_err = 1'b0;
   endtask

   // polling faster than the check interval keeps the drive alive
   task automatic poll(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         send(1'b0);
         repeat (gap) @(posedge ref_clk);
         #2;
      end
   endtask
endmodule // ecs_host_model

//--- dv/comm_error_supervisor_bench.sv
// self-checking bench of the link error supervisor
`timescale 1ns/1ps
module comm_error_supervisor_bench;
   logic                          ref_clk;
   logic                          rst_n;
   logic                          frame_ok, frame_err;
   logic                          protocol_sel;
   logic [ecs_pkg::SET_W-1:0]     retry_lim;
   logic [ecs_pkg::SET_W-1:0]     chk_int;
   logic [1:0]                    stop_mode;
   logic                          net_mode;
   logic                          motor_stopped;
   logic                          fault_reset_pin;
   logic                          run_cmd_in;
   logic [ecs_pkg::SPEED_W-1:0]   speed_cmd_in;
   logic [ecs_pkg::FUNC_W-1:0]    term_fn_a, term_fn_b, term_fn_c;
   logic                          coast_cmd, decel_cmd, accel_restart, run_cmd_out;
   logic [ecs_pkg::SPEED_W-1:0]   speed_cmd_out;
   logic                          link_fault_trip, fault_output, fault_history_wr;
   logic                          minor_fault_alarm;
   logic [ecs_pkg::TERM_N-1:0]    term_out;
   int                            num_errors = 0;
   int                            num_checks = 0;
   int                            hist_cnt = 0;
   int                            acc_cnt = 0;

   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (fault_history_wr === 1'b1) hist_cnt++;
   // restart pulse lasts one cycle: count it rather than poll for it
   always @(posedge ref_clk) if (accel_restart === 1'b1) acc_cnt++;

   ecs_host_model i_host (.ref_clk(ref_clk), .frame_ok(frame_ok), .frame_err(frame_err));

   ecs_supervisor #(.TICK_CYCLES(10)) i_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .frame_ok(frame_ok), .frame_err(frame_err),
      .protocol_sel(protocol_sel), .retry_limit_setting(retry_lim),
      .check_interval_setting(chk_int), .fault_stop_mode(stop_mode),
      .output_terminal_function_a(term_fn_a), .output_terminal_function_b(term_fn_b),
      .output_terminal_function_c(term_fn_c), .network_command_mode(net_mode),
      .motor_stopped(motor_stopped), .fault_reset_pin(fault_reset_pin),
      .run_cmd_in(run_cmd_in), .speed_cmd_in(speed_cmd_in), .coast_cmd(coast_cmd),
      .decel_cmd(decel_cmd), .accel_restart(accel_restart), .run_cmd_out(run_cmd_out),
      .speed_cmd_out(speed_cmd_out), .link_fault_trip(link_fault_trip),
      .fault_output(fault_output), .fault_history_wr(fault_history_wr),
      .minor_fault_alarm(minor_fault_alarm), .term_out(term_out));

   task automatic end_sim;
      if (num_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask

   // sel 0 trip up, 1 decel up, 2 restart pulse, 3 trip down
   task automatic wait_for(input int sel, input int n);
      int  k;
      logic hit;
      k = 0;
      hit = 1'b0;
      while (k < n && !hit) begin
         tk(1);
         k++;
         case (sel)
            0: hit = (link_fault_trip === 1'b1);
            1: hit = (decel_cmd === 1'b1);
            2: hit = (accel_restart === 1'b1);
            default: hit = (link_fault_trip === 1'b0);
         endcase
      end
      chk({15'h0000, hit}, 16'h0001);
   endtask

   initial begin
      #400000;
      num_errors++;
      end_sim();
   end

   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      protocol_sel = 1'b0;
      retry_lim = 14'h0002;
      chk_int = 14'h270F;
      stop_mode = 2'h0;
      net_mode = 1'b0;
      motor_stopped = 1'b0;
      fault_reset_pin = 1'b0;
      run_cmd_in = 1'b1;
      speed_cmd_in = 16'h1234;
      term_fn_a = 8'h62;
      term_fn_b = 8'hC6;
      term_fn_c = 8'h00;
      tk(12);
      chk({13'h0000, term_out}, 16'h0002);
      chk({15'h0000, link_fault_trip}, 16'h0000);
      rst_n = 1'b1;
      tk(2);
      // ---------------------------------------------------
      // retry counting, cleared by a good frame, coast stop
      // ---------------------------------------------------
      i_host.send(1'b1);
      i_host.send(1'b1);
      i_host.send(1'b0);
      i_host.send(1'b1);
      i_host.send(1'b1);
      tk(4);
      chk({15'h0000, link_fault_trip}, 16'h0000);
      i_host.send(1'b1);
      wait_for(0, 6);
      chk({14'h0000, coast_cmd, fault_output}, 16'h0003);
      tk(2);
      chk(16'(hist_cnt), 16'h0001);
      fault_reset_pin = 1'b1;
      wait_for(3, 8);
      fault_reset_pin = 1'b0;
      // ---------------------------------------------------
      // second protocol ignores the retry limit
      // ---------------------------------------------------
      protocol_sel = 1'b1;
      retry_lim = 14'h0000;
      repeat (3) i_host.send(1'b1);
      tk(4);
      chk({14'h0000, link_fault_trip, minor_fault_alarm}, 16'h0000);
      protocol_sel = 1'b0;
      // ---------------------------------------------------
      // alarm-only limit and terminal polarity
      // ---------------------------------------------------
      retry_lim = 14'h270F;
      i_host.send(1'b1);
      tk(2);
      chk({12'h000, minor_fault_alarm, term_out}, 16'h0009);
      term_fn_a = 8'hC6;
      term_fn_b = 8'h00;
      term_fn_c = 8'h62;
      tk(1);
      chk({12'h000, minor_fault_alarm, term_out}, 16'h000C);
      term_fn_a = 8'h62;
      term_fn_b = 8'hC6;
      term_fn_c = 8'h00;
      repeat (2) i_host.send(1'b1);
      tk(4);
      chk({15'h0000, link_fault_trip}, 16'h0000);
      i_host.send(1'b0);
      tk(2);
      chk({12'h000, minor_fault_alarm, term_out}, 16'h0002);
      // ---------------------------------------------------
      // signal loss: off, arming, polling, expiry, restart
      // ---------------------------------------------------
      retry_lim = 14'h000A;
      net_mode = 1'b1;
      i_host.send(1'b0);
      tk(80);
      chk({15'h0000, decel_cmd | link_fault_trip}, 16'h0000);
      net_mode = 1'b0;
      chk_int = 14'h0003;
      stop_mode = 2'h2;
      tk(2);
      net_mode = 1'b1;
      tk(80);
      chk({15'h0000, decel_cmd}, 16'h0000);
      i_host.poll(6, 18);
      chk({15'h0000, decel_cmd}, 16'h0000);
      tk(15);
      chk({15'h0000, decel_cmd}, 16'h0000);
      wait_for(1, 40);
      speed_cmd_in = 16'h5678;
      tk(2);
      chk(speed_cmd_out, 16'h1234);
      chk({15'h0000, link_fault_trip}, 16'h0000);
      i_host.send(1'b0);
      tk(1);
      chk(16'(acc_cnt), 16'h0001);
      wait_for(1, 70);
      motor_stopped = 1'b1;
      wait_for(0, 4);
      chk({15'h0000, fault_output}, 16'h0000);
      chk(16'(hist_cnt), 16'h0001);
      i_host.send(1'b0);
      tk(1);
      chk(16'(acc_cnt), 16'h0002);
      motor_stopped = 1'b0;
      chk({run_cmd_out, 15'h0000}, 16'h8000);
      chk(speed_cmd_out, 16'h5678);
      // ---------------------------------------------------
      // zero interval trips on entering network mode
      // ---------------------------------------------------
      net_mode = 1'b0;
      chk_int = 14'h0000;
      stop_mode = 2'h1;
      tk(3);
      chk({15'h0000, link_fault_trip | decel_cmd}, 16'h0000);
      net_mode = 1'b1;
      wait_for(1, 4);
      motor_stopped = 1'b1;
      wait_for(0, 4);
      chk({15'h0000, fault_output}, 16'h0001);
      tk(2);
      chk(16'(hist_cnt), 16'h0002);
      // mid-run reset drops the held fault
      rst_n = 1'b0;
      tk(2);
      chk({10'h000, link_fault_trip, fault_output, minor_fault_alarm, term_out}, 16'h0002);
      rst_n = 1'b1;
      tk(1);
      chk({15'h0000, decel_cmd}, 16'h0001);
      end_sim();
   end
endmodule // comm_error_supervisor_bench
